// >>> rtf_consts.svh
`ifndef RTF_CONSTS_SVH
`define RTF_CONSTS_SVH

// ****************************************************************
// Register word indices (byte address is index times four)
// ****************************************************************
`define RTF_IDX_SIGNED_HIGH     8'h01
`define RTF_IDX_SIGNED_LOW      8'h10
`define RTF_IDX_OFFSET_HIGH     8'h11
`define RTF_IDX_OFFSET_LOW      8'h12
`define RTF_IDX_UNSIGNED_HIGH   8'h31
`define RTF_IDX_UNSIGNED_LOW    8'h32
`define RTF_IDX_CONFIG          8'h45
`define RTF_IDX_FILTER          8'h46

// ****************************************************************
// Field positions
// ****************************************************************
`define RTF_CFG_EXT_RES_BIT     0
`define RTF_FLT_ENABLE_BIT      0
`define RTF_FRAC_LSB            3
`define RTF_OFS_LOW_MASK        8'hE0

// ****************************************************************
// Reset values
// ****************************************************************
`define RTF_OFFSET_RESET        8'h00
`define RTF_CONFIG_RESET        8'h00
`define RTF_FILTER_RESET        8'h00

// ****************************************************************
// Fixed values
// ****************************************************************
// Readings of 128.0 degC and above, in 1/32 degC units (corrected value >= 128.0)
`define RTF_EXT_THRESHOLD       16'h1000
// Clamp bounds of the offset-corrected value, in 1/32 degC units
`define RTF_SIGNED_MAX          16'h1FFF
`define RTF_SIGNED_MIN          16'hE000
`define RTF_UNSIGNED_MAX        16'h1FFF

`endif

// >>> rtf_format.sv
`timescale 1ns/10ps
`default_nettype none

`include "rtf_consts.svh"

// ****************************************************************
// Combinational formatter from corrected value to result bytes
// ****************************************************************
module rtf_format (
	// Corrected value, signed, 1/32 degC units
	input  wire logic signed [15:0]   corrected,
	// Mode controls
	input  wire logic                 filter_on,
	input  wire logic                 ext_res,
	// Result bytes
	output var rtf_pkg::rtf_result_s  result
);

	logic signed [15:0] sclamp;
	logic        [15:0] uclamp;
	logic        [1:0]  sfine;
	logic        [1:0]  ufine;

	// Saturation into the two ranges
	always_comb begin
		if (corrected > $signed(`RTF_SIGNED_MAX))
			sclamp = $signed(`RTF_SIGNED_MAX);
		else if (corrected < $signed(`RTF_SIGNED_MIN))
			sclamp = $signed(`RTF_SIGNED_MIN);
		else
			sclamp = corrected;
		if (corrected < 0)
			uclamp = 16'h0000;
		else if (corrected > $signed(`RTF_UNSIGNED_MAX))
			uclamp = `RTF_UNSIGNED_MAX;
		else
			uclamp = corrected;
	end

	// Fine fraction bit selection
	always_comb begin
		if (filter_on && ext_res)
			sfine = sclamp[1:0];
		else if (ext_res)
			sfine = (corrected >= $signed(`RTF_EXT_THRESHOLD))
				? 2'b11 : 2'b00;
		else
			sfine = 2'b00;
		ufine = filter_on ? uclamp[1:0] : 2'b00;
	end

	// Byte packing, unused low bits read zero
	always_comb begin
		result.signed_high   = sclamp[12:5];
		result.signed_low    = {sclamp[4:2], sfine, 3'b000};
		result.unsigned_high = uclamp[12:5];
		result.unsigned_low  = {3'b000, uclamp[4:2], ufine};
	end

endmodule

`default_nettype wire

// >>> rtf_pkg.sv
package rtf_pkg;

	// Sample path state
	typedef enum logic [1:0] {
		RTF_IDLE  = 2'b01,
		RTF_APPLY = 2'b10
	} rtf_state_e;

	// Formatted readings, four result bytes
	typedef struct packed {
		logic [7:0] signed_high;
		logic [7:0] signed_low;
		logic [7:0] unsigned_high;
		logic [7:0] unsigned_low;
	} rtf_result_s;

endpackage

// >>> rtf_top.sv
// Summary of operation
// - Signed low byte top bits carry half, quarter, eighth degree fraction.
// - Filter off: signed fine bits zero unless extended resolution is set.
// - Extended resolution, filter off: fine bits 11 from 128.0 up, else 00.
// - Filter and extended resolution on: fine bits weigh 1/16 and 1/32.
// - Unused bits of both low bytes read as zero: signed bits 2..0, unsigned bits 7..5.
// - Unsigned high byte is integer degrees, top bit 128, lowest 1.
// - Unsigned low byte bits 4..2 weigh half, quarter, eighth degree.
// - Filter off: unsigned fine bits held at zero.
// - Filter on: unsigned bits 1..0 weigh 1/16 and 1/32 degree.
// - Programmed signed offset is added to each converter sample taken while idle.
// - Offset high byte and low byte bits 7..5, both reset to zero.
// - Signed high byte is two's complement integer, sign on top, for readings from -128.0 to below 128.0.

`timescale 1ns/10ps
`default_nettype none

`include "rtf_consts.svh"

// ****************************************************************
// Remote temperature result formatting with Wishbone registers
// ****************************************************************
module rtf_top (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Converter sample, signed, 1/32 degC units
	input  wire logic [15:0] SAMPLE,
	input  wire logic        SAMPLE_VALID,
	// Wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [9:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	output logic             ERR_O
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		rtf_pkg::rtf_state_e  state;
		logic [15:0]          raw;
		logic [7:0]           ofs_high;
		logic [7:0]           ofs_low;
		logic [7:0]           config_reg;
		logic [7:0]           filter_reg;
		rtf_pkg::rtf_result_s result;
		logic [7:0]           signed_low_hold;
		logic [7:0]           unsigned_low_hold;
		logic                 ack;
		logic                 err;
		logic [31:0]          rdata;
	} rtf_regs_s;

	rtf_regs_s r;
	rtf_regs_s next_r;

	// ****************************************************************
	// Register map
	// ****************************************************************
	// Entry numbers, one per register
	localparam int ent_sig_high = 0;
	localparam int ent_sig_low  = 1;
	localparam int ent_ofs_high = 2;
	localparam int ent_ofs_low  = 3;
	localparam int ent_uns_high = 4;
	localparam int ent_uns_low  = 5;
	localparam int ent_config   = 6;
	localparam int ent_filter   = 7;
	localparam int num_regs     = 8;

	// Word index of each entry, entry 0 in the lowest byte
	localparam logic [num_regs-1:0][7:0] reg_idx = {
		`RTF_IDX_FILTER,
		`RTF_IDX_CONFIG,
		`RTF_IDX_UNSIGNED_LOW,
		`RTF_IDX_UNSIGNED_HIGH,
		`RTF_IDX_OFFSET_LOW,
		`RTF_IDX_OFFSET_HIGH,
		`RTF_IDX_SIGNED_LOW,
		`RTF_IDX_SIGNED_HIGH
	};

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic signed [15:0]       offset_val;
	logic signed [15:0]       corrected;
	rtf_pkg::rtf_result_s     formatted;
	logic                     req;
	logic                     wr_low_lane;
	logic [7:0]               word_idx;
	logic                     aligned;
	logic [num_regs-1:0]      hit;
	logic                     mapped;
	logic [num_regs-1:0][7:0] reg_val;
	logic [7:0]               rd_byte;
	logic                     wr_go;
	logic                     rd_go;
	logic                     wr_ofs_high;
	logic                     wr_ofs_low;
	logic                     wr_config;
	logic                     wr_filter;
	logic                     rd_sig_high;
	logic                     rd_uns_high;
	logic [7:0]               wr_byte;
	logic                     sample_take;

	// Offset in 1/32 degC units, eighth-degree resolution
	assign offset_val = {{3{r.ofs_high[7]}}, r.ofs_high,
		r.ofs_low[7:5], 2'b00};

	// Corrected value from last sample
	assign corrected = $signed(r.raw) + offset_val;

	// ****************************************************************
	// Formatter
	// ****************************************************************
	rtf_format u_format (
		.corrected (corrected),
		.filter_on (r.filter_reg[`RTF_FLT_ENABLE_BIT]),
		.ext_res   (r.config_reg[`RTF_CFG_EXT_RES_BIT]),
		.result    (formatted)
	);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	// Request qualification and byte address split
	assign req         = CYC_I && STB_I && !r.ack && !r.err;
	assign wr_low_lane = WE_I && SEL_I[0];
	assign word_idx    = ADR_I[9:2];
	assign aligned     = (ADR_I[1:0] == 2'b00);

	// One hit line per register, misaligned addresses hit nothing
	for (genvar g = 0; g < num_regs; g++) begin : g_hit
		assign hit[g] = aligned && (word_idx == reg_idx[g]);
	end

	// Any hit makes the access legal
	assign mapped = |hit;

	// ****************************************************************
	// Register read values
	// ****************************************************************
	// Low result bytes come from the copies frozen by high-byte reads
	always_comb begin
		reg_val               = '0;
		reg_val[ent_sig_high] = r.result.signed_high;
		reg_val[ent_sig_low]  = r.signed_low_hold;
		reg_val[ent_ofs_high] = r.ofs_high;
		reg_val[ent_ofs_low]  = r.ofs_low;
		reg_val[ent_uns_high] = r.result.unsigned_high;
		reg_val[ent_uns_low]  = r.unsigned_low_hold;
		reg_val[ent_config]   = r.config_reg;
		reg_val[ent_filter]   = r.filter_reg;
	end

	// One-hot read selection, zero when nothing hits
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < num_regs; i++) begin
			if (hit[i])
				rd_byte = rd_byte | reg_val[i];
		end
	end

	// ****************************************************************
	// Access strobes
	// ****************************************************************
	// Accepted mapped reads and low-lane writes
	assign wr_go = req && mapped && wr_low_lane;
	assign rd_go = req && mapped && !WE_I;

	// Per-register write strobes, read-only entries have none
	assign wr_ofs_high = wr_go && hit[ent_ofs_high];
	assign wr_ofs_low  = wr_go && hit[ent_ofs_low];
	assign wr_config   = wr_go && hit[ent_config];
	assign wr_filter   = wr_go && hit[ent_filter];

	// High-byte reads that freeze the matching low byte
	assign rd_sig_high = rd_go && hit[ent_sig_high];
	assign rd_uns_high = rd_go && hit[ent_uns_high];

	// Write byte, lane 0 only
	assign wr_byte = DAT_I[7:0];

	// Converter sample taken only while idle
	assign sample_take = SAMPLE_VALID && (r.state == rtf_pkg::RTF_IDLE);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_r     = r;
		next_r.ack = 1'b0;
		next_r.err = 1'b0;

		// Sample capture, then result update one cycle later
		case (r.state)
		rtf_pkg::RTF_IDLE: begin
			if (sample_take) begin
				next_r.raw   = SAMPLE;
				next_r.state = rtf_pkg::RTF_APPLY;
			end
		end
		rtf_pkg::RTF_APPLY: begin
			next_r.result = formatted;
			next_r.state  = rtf_pkg::RTF_IDLE;
		end
		default: next_r.state = rtf_pkg::RTF_IDLE;
		endcase

		// Bus answer, one cycle after the request is taken
		if (req) begin
			next_r.ack   = mapped;
			next_r.err   = !mapped;
			next_r.rdata = mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end

		// High-byte read freezes the matching low byte
		if (rd_sig_high)
			next_r.signed_low_hold = r.result.signed_low;
		if (rd_uns_high)
			next_r.unsigned_low_hold = r.result.unsigned_low;

		// Register writes
		if (wr_ofs_high)
			next_r.ofs_high = wr_byte;
		if (wr_ofs_low)
			next_r.ofs_low = wr_byte & `RTF_OFS_LOW_MASK;
		if (wr_config)
			next_r.config_reg = wr_byte;
		if (wr_filter)
			next_r.filter_reg = wr_byte;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			r.state             <= rtf_pkg::RTF_IDLE;
			r.raw               <= 16'h0000;
			r.ofs_high          <= `RTF_OFFSET_RESET;
			r.ofs_low           <= `RTF_OFFSET_RESET;
			r.config_reg        <= `RTF_CONFIG_RESET;
			r.filter_reg        <= `RTF_FILTER_RESET;
			r.result            <= '0;
			r.signed_low_hold   <= 8'h00;
			r.unsigned_low_hold <= 8'h00;
			r.ack               <= 1'b0;
			r.err               <= 1'b0;
			r.rdata             <= 32'h0000_0000;
		end else begin
			r <= next_r;
		end
	end

	// Outputs
	assign DAT_O = r.rdata;
	assign ACK_O = r.ack;
	assign ERR_O = r.err;

endmodule

`default_nettype wire

// >>> rtf_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// ****
// Bus answer checks
// ****
module rtf_top_assertions (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Bus signals
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic [9:0]  ADR_I,
	input  wire logic [31:0] DAT_O,
	input  wire logic        ACK_O,
	input  wire logic        ERR_O
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// Accepted request, then its single answer
	sequence req_s;
		CYC_I && STB_I && !ACK_O && !ERR_O;
	endsequence
	sequence ans_s;
		ACK_O ^ ERR_O;
	endsequence

	// Handshake timing
	ack_latency_a: assert property (req_s |=> ans_s)
		else $error("no single answer one cycle after request");
	ack_pulse_a: assert property (ACK_O |=> !ACK_O)
		else $error("ack held longer than one cycle");
	idle_quiet_a: assert property (!(CYC_I && STB_I) |=> !ACK_O && !ERR_O)
		else $error("answer without request");
	// Refusals and zero upper read data
	err_unmapped_a: assert property (
		req_s and (ADR_I == 10'h0FC) |=> ERR_O)
		else $error("unmapped address not refused");
	err_misalign_a: assert property (
		req_s and (ADR_I[1:0] != 2'b00) |=> ERR_O)
		else $error("misaligned address not refused");
	err_data_a: assert property (ERR_O |-> DAT_O == 32'h0000_0000)
		else $error("data not zero on refusal");
	upper_zero_a: assert property (ACK_O |-> DAT_O[31:8] == '0)
		else $error("upper read data not zero");
	// Unused bits of read bytes
	slow_unused_a: assert property (
		req_s and (ADR_I == 10'h040) |=> DAT_O[2:0] == 3'h0)
		else $error("signed low unused bits not zero");
	ulow_unused_a: assert property (
		req_s and (ADR_I == 10'h0C8) |=> DAT_O[7:5] == 3'h0)
		else $error("unsigned low unused bits not zero");
	ofs_mask_a: assert property (
		req_s and (ADR_I == 10'h048) |=> DAT_O[4:0] == 5'h00)
		else $error("offset low unused bits not zero");
endmodule

`default_nettype wire

// >>> rtf_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`include "rtf_consts.svh"

// ****
// Testbench
// ****
module rtf_top_tb_top;
	logic                 clk, rst, sv, cyc, stb, we, ack, err, ef;
	logic [15:0]          smp;
	logic [9:0]           adr;
	logic [7:0]           q;
	logic [31:0]          dat_i, dat_o;
	int                   err_count, tests_run;
	logic [15:0]          ts [6] = '{16'h0ABF, 16'h0ABF, 16'h0FFC,
		16'h1003, 16'hFF5A, 16'h0ABF};
	logic [1:0]           tm [6] = '{2'b00, 2'b11, 2'b01, 2'b01, 2'b11, 2'b10};

	// Device under test
	rtf_top i_dut (.CLK(clk), .RST(rst), .SAMPLE(smp), .SAMPLE_VALID(sv),
		.CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF),
		.DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .ERR_O(err));

	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
		tests_run++;
		if (s !== x) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask

	// One classic bus cycle, waits for ack or err
	task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d,
		input logic [1:0] lo = 2'b00);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, lo};
		dat_i <= 32'(d);
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 16);
		if (ack !== 1'b1 && err !== 1'b1) err_count++;
		q = dat_o[7:0];
		ef = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Register read and compare
	task automatic rd(input logic [7:0] ix, input logic [7:0] x, input string n);
		wb(1'b0, ix, 8'h00);
		chk(n, q, x);
	endtask

	// Converter sample, then wait for the results
	task automatic feed(input logic [15:0] s);
		@(posedge clk);
		smp <= s;
		sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Filter and extended resolution controls
	task automatic mode(input logic f, input logic e);
		wb(1'b1, `RTF_IDX_FILTER, {7'h00, f});
		wb(1'b1, `RTF_IDX_CONFIG, {7'h00, e});
	endtask

	// Expected bytes from a corrected value in 1/32 degC
	function automatic rtf_pkg::rtf_result_s ex(input logic [15:0] c,
		input logic f, input logic e);
		rtf_pkg::rtf_result_s r;
		logic [1:0] fn;
		fn = (f && e) ? c[1:0] : (e && !c[15] && c >= 16'h1000) ? 2'b11 : 2'b00;
		r.signed_high = c[12:5];
		r.signed_low = {c[4:2], fn, 3'b000};
		r.unsigned_high = c[15] ? 8'h00 : c[12:5];
		r.unsigned_low = c[15] ? 8'h00 : {3'b000, c[4:2], f ? c[1:0] : 2'b00};
		return r;
	endfunction

	// All four result bytes, high before low
	task automatic rd4(input rtf_pkg::rtf_result_s x);
		rd(`RTF_IDX_SIGNED_HIGH, x.signed_high, "signed_high");
		rd(`RTF_IDX_SIGNED_LOW, x.signed_low, "signed_low");
		rd(`RTF_IDX_UNSIGNED_HIGH, x.unsigned_high, "unsigned_high");
		rd(`RTF_IDX_UNSIGNED_LOW, x.unsigned_low, "unsigned_low");
	endtask

	// Reset values and refusals
	task automatic t_reset();
		rd(`RTF_IDX_OFFSET_HIGH, 8'h00, "offset_high");
		rd(`RTF_IDX_OFFSET_LOW, 8'h00, "offset_low");
		rd(`RTF_IDX_SIGNED_LOW, 8'h00, "low_before_high");
		wb(1'b0, 8'h3F, 8'h00);
		chk("unmapped_err", {7'h00, ef}, 8'h01);
		wb(1'b0, `RTF_IDX_SIGNED_HIGH, 8'h00, 2'b01);
		chk("misaligned_err", {7'h00, ef}, 8'h01);
		$display("test reset done");
	endtask

	// Formatting in each mode, boundary at 127.875
	task automatic t_fmt();
		for (int i = 0; i < 6; i++) begin
			mode(tm[i][1], tm[i][0]);
			feed(ts[i]);
			rd4(ex(ts[i], tm[i][1], tm[i][0]));
		end
		$display("test format done");
	endtask

	// Offset masking and addition
	task automatic t_ofs();
		wb(1'b1, `RTF_IDX_OFFSET_HIGH, 8'hFE);
		wb(1'b1, `RTF_IDX_OFFSET_LOW, 8'hBF);
		rd(`RTF_IDX_OFFSET_HIGH, 8'hFE, "offset_high");
		rd(`RTF_IDX_OFFSET_LOW, 8'hA0, "offset_low");
		mode(1'b1, 1'b1);
		feed(16'h0ABF);
		rd4(ex(16'h0ABF + 16'({3'b111, 8'hFE, 3'b101, 2'b00}), 1'b1, 1'b1));
		wb(1'b1, `RTF_IDX_OFFSET_HIGH, 8'h00);
		wb(1'b1, `RTF_IDX_OFFSET_LOW, 8'h00);
		$display("test offset done");
	endtask

	// Low byte held from the sample of the high read
	task automatic t_latch();
		rtf_pkg::rtf_result_s e0;
		e0 = ex(16'h0ABF, 1'b1, 1'b1);
		mode(1'b1, 1'b1);
		feed(16'h0ABF);
		rd(`RTF_IDX_SIGNED_HIGH, 8'h55, "latch_high");
		feed(16'h0123);
		rd(`RTF_IDX_SIGNED_LOW, e0.signed_low, "latch_low");
		rd4(ex(16'h0123, 1'b1, 1'b1));
		$display("test latch done");
	endtask

	// Verdict and end of run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#(25 * 5000);
		err_count++;
		finish_test();
	end

	// Main sequence
	initial begin
		{rst, sv, cyc, stb, we, adr, dat_i, smp} = '0;
		rst = 1'b1;
		err_count = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_fmt();
		t_ofs();
		t_latch();
		finish_test();
	end
endmodule

// Checker attachment
bind rtf_top rtf_top_assertions i_chk (.CLK(CLK), .RST(RST), .CYC_I(CYC_I),
	.STB_I(STB_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O));

`default_nettype wire
